// ==== common/ccsbd_pkg.sv ====
// ccsbd_pkg: opcode patterns, field positions, status bit positions and
// cycle counts shared by the call/compare/skip/branch decode block.
// assumes 16-bit instruction words and an 8-bit status register.
package ccsbd_pkg;

  // instruction word and field widths
  localparam int IW  = 16;
  localparam int DW  = 8;
  localparam int RAW = 5;

  // opcode mask/pattern pairs, and the whole call opcode
  localparam logic [15:0] OPC_CALL   = 16'h9509;
  localparam logic [15:0] MSK_CSKP   = 16'hfc00;
  localparam logic [15:0] PAT_CSKP   = 16'h1000;
  localparam logic [15:0] MSK_CIMM   = 16'hf000;
  localparam logic [15:0] PAT_CIMM   = 16'h3000;
  localparam logic [15:0] MSK_RBIT   = 16'hfe08;
  localparam logic [15:0] PAT_RCLR   = 16'hfc00;
  localparam logic [15:0] PAT_RSET   = 16'hfe00;
  localparam logic [15:0] MSK_IOCLR  = 16'hff00;
  localparam logic [15:0] PAT_IOCLR  = 16'h9900;
  localparam logic [15:0] MSK_BRF    = 16'hfc00;
  localparam logic [15:0] PAT_BRF    = 16'hf000;

  // two-word instructions: direct load/store and absolute jump/call
  localparam logic [15:0] MSK_LDST2  = 16'hfc0f;
  localparam logic [15:0] PAT_LDST2  = 16'h9000;
  localparam logic [15:0] MSK_JMPC2  = 16'hfe0c;
  localparam logic [15:0] PAT_JMPC2  = 16'h940c;

  // field positions
  localparam int F_RD_LO   = 4;
  localparam int F_RD_HI   = 8;
  localparam int F_SRC_HI  = 9;
  localparam int F_BIT_HI  = 2;
  localparam int F_IO_LO   = 3;
  localparam int F_IO_HI   = 7;
  localparam int F_K7_LO   = 3;
  localparam int F_K7_HI   = 9;

  // status register bit positions
  localparam int SB_C = 0;
  localparam int SB_Z = 1;
  localparam int SB_N = 2;
  localparam int SB_V = 3;
  localparam int SB_H = 5;

  // cycle counts
  localparam logic [1:0] LAT_ONE    = 2'h1;
  localparam logic [1:0] LAT_SKIP1  = 2'h2;
  localparam logic [1:0] LAT_SKIP2  = 2'h3;
  localparam logic [1:0] LAT_BRANCH = 2'h2;
  localparam logic [1:0] LAT_CALL   = 2'h3;

  // pc increments
  localparam logic [15:0] PC_STEP   = 16'h0001;
  localparam logic [15:0] PC_SKIP1  = 16'h0002;
  localparam logic [15:0] PC_SKIP2  = 16'h0003;

  // reset values
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [7:0]  STAT_RST  = 8'h00;

  // sequencer states, gray along idle -> exec
  typedef enum logic [1:0] {
    CCSBD_IDLE = 2'b00,
    CCSBD_EXEC = 2'b01
  } ccsbd_state_t;

endpackage : ccsbd_pkg

// ==== rtl/ccsbd_cmp_flags.sv ====
// ccsbd_cmp_flags: register minus immediate, result discarded, flags out.
// assumes operands are stable in the cycle they are presented.
`timescale 1ns/1ps
module ccsbd_cmp_flags
  import ccsbd_pkg::*;
(
  // operands
  input  wire logic [DW-1:0] dst_in,
  input  wire logic [DW-1:0] imm_in,
  // status in and merged status out
  input  wire logic [DW-1:0] status_in,
  output logic      [DW-1:0] status_out
);

  logic [DW-1:0] diff;
  logic          f_z;
  logic          f_n;
  logic          f_v;
  logic          f_c;
  logic          f_h;

  // subtract only; the difference never reaches the register file
  assign diff = dst_in - imm_in;
  assign f_z  = (diff == 8'h00);
  assign f_n  = diff[7];
  assign f_v  = (dst_in[7] & ~imm_in[7] & ~diff[7]) | (~dst_in[7] & imm_in[7] & diff[7]);
  assign f_c  = (~dst_in[7] & imm_in[7]) | (imm_in[7] & diff[7]) | (diff[7] & ~dst_in[7]);
  assign f_h  = (~dst_in[3] & imm_in[3]) | (imm_in[3] & diff[3]) | (diff[3] & ~dst_in[3]);

  // other status bits pass through untouched
  always_comb begin
    status_out       = status_in;
    status_out[SB_Z] = f_z;
    status_out[SB_N] = f_n;
    status_out[SB_V] = f_v;
    status_out[SB_C] = f_c;
    status_out[SB_H] = f_h;
  end

endmodule : ccsbd_cmp_flags

// ==== rtl/ccsbd_decode.sv ====
// ccsbd_decode: decode and execute for indirect call, compare-and-skip,
// compare with immediate, register/io bit skips and branch on status flag.
// assumes register file, io and status reads answer in the same cycle,
// and that fetch presents the word after the current one on next_word_in.
`timescale 1ns/1ps
module ccsbd_decode
  import ccsbd_pkg::*;
(
  // clock and reset
  input  wire logic            sys_clk_in,
  input  wire logic            sys_rst_in,
  // instruction from fetch
  input  wire logic            instr_valid_in,
  input  wire logic [IW-1:0]   instr_in,
  input  wire logic [IW-1:0]   next_word_in,
  input  wire logic [15:0]     pc_in,
  output logic                 ready_out,
  // register file read ports
  output logic      [RAW-1:0]  rd_addr_out,
  output logic      [RAW-1:0]  src_addr_out,
  input  wire logic [DW-1:0]   rd_data_in,
  input  wire logic [DW-1:0]   src_data_in,
  // io register read port
  output logic      [RAW-1:0]  io_addr_out,
  input  wire logic [DW-1:0]   io_data_in,
  // pointer register pair
  input  wire logic [15:0]     ptr_in,
  // status register
  input  wire logic [DW-1:0]   status_in,
  output logic      [DW-1:0]   status_out,
  output logic                 status_wr_out,
  // program counter and return address
  output logic                 done_out,
  output logic                 op_hit_out,
  output logic                 pc_load_out,
  output logic      [15:0]     pc_next_out,
  output logic                 ret_push_out,
  output logic      [15:0]     ret_addr_out
);

  // mask/pattern match, used for every opcode group but the call, which compares the whole word
  function automatic logic op_match(input logic [15:0] w, input logic [15:0] m,
                                    input logic [15:0] p);
    op_match = ((w & m) == p);
  endfunction : op_match

  // the word that a skip passes over may be one or two words long
  function automatic logic two_word(input logic [15:0] w);
    two_word = op_match(w, MSK_LDST2, PAT_LDST2) | op_match(w, MSK_JMPC2, PAT_JMPC2);
  endfunction : two_word

  ccsbd_state_t  state_r;
  ccsbd_state_t  state_nxt;
  logic [1:0]    cnt_r;
  logic [1:0]    cnt_nxt;
  logic          done_r;
  logic          done_nxt;
  logic          hit_r;
  logic [15:0]   pc_next_r;
  logic [15:0]   ret_addr_r;
  logic [DW-1:0] status_r;
  logic          st_wr_r;
  logic          push_r;

  // opcode group decode
  wire is_call  = (instr_in == OPC_CALL);
  wire is_cskp  = op_match(instr_in, MSK_CSKP, PAT_CSKP);
  wire is_cimm  = op_match(instr_in, MSK_CIMM, PAT_CIMM);
  wire is_rclr  = op_match(instr_in, MSK_RBIT, PAT_RCLR);
  wire is_rset  = op_match(instr_in, MSK_RBIT, PAT_RSET);
  wire is_ioclr = op_match(instr_in, MSK_IOCLR, PAT_IOCLR);
  wire is_brf   = op_match(instr_in, MSK_BRF, PAT_BRF);
  wire is_skip  = is_cskp | is_rclr | is_rset | is_ioclr;
  wire is_any   = is_call | is_cskp | is_cimm | is_skip | is_brf;

  // operand fields
  wire [2:0]    bit_sel  = instr_in[F_BIT_HI:0];
  wire [6:0]    br_off7  = instr_in[F_K7_HI:F_K7_LO];
  wire [DW-1:0] imm_k    = {instr_in[11:8], instr_in[3:0]};
  wire          take     = instr_valid_in & ready_out;

  // register addressing; the immediate compare only reaches the upper half
  assign rd_addr_out  = is_cimm ? {1'b1, instr_in[7:4]} : instr_in[F_RD_HI:F_RD_LO];
  assign src_addr_out = {instr_in[F_SRC_HI], instr_in[3:0]};
  assign io_addr_out  = instr_in[F_IO_HI:F_IO_LO];

  // skip conditions
  wire reg_bit   = rd_data_in[bit_sel];
  wire io_bit    = io_data_in[bit_sel];
  wire cskp_hit  = is_cskp & (rd_data_in == src_data_in);
  wire rclr_hit  = is_rclr & ~reg_bit;
  wire rset_hit  = is_rset & reg_bit;
  wire ioclr_hit = is_ioclr & ~io_bit;
  wire skip_hit  = cskp_hit | rclr_hit | rset_hit | ioclr_hit;
  wire skip_two  = two_word(next_word_in);

  // branch condition and target
  wire          br_taken  = is_brf & status_in[bit_sel];
  wire [15:0]   br_off    = {{9{br_off7[6]}}, br_off7};
  wire [15:0]   br_target = pc_in + br_off + PC_STEP;
  wire [15:0]   pc_seq    = pc_in + PC_STEP;

  // skip distance: 2 over a one-word, 3 over a two-word instruction
  wire [15:0]   skip_pc   = pc_in + (skip_two ? PC_SKIP2 : PC_SKIP1);
  wire [1:0]    skip_lat  = skip_two ? LAT_SKIP2 : LAT_SKIP1;

  // flags from the immediate compare
  logic [DW-1:0] cimm_status;

  ccsbd_cmp_flags u_cmp (
    .dst_in     (rd_data_in),
    .imm_in     (imm_k),
    .status_in  (status_in),
    .status_out (cimm_status)
  );

  // next pc selection, priority by opcode group
  logic [15:0] pc_sel;
  always_comb begin
    if (is_call) begin
      pc_sel = ptr_in;
    end else if (is_skip & skip_hit) begin
      pc_sel = skip_pc;
    end else if (br_taken) begin
      pc_sel = br_target;
    end else begin
      pc_sel = pc_seq;
    end
  end

  // cycle count of the instruction taken this cycle
  logic [1:0] lat_sel;
  always_comb begin
    if (is_call) begin
      lat_sel = LAT_CALL;
    end else if (is_skip & skip_hit) begin
      lat_sel = skip_lat;
    end else if (br_taken) begin
      lat_sel = LAT_BRANCH;
    end else begin
      lat_sel = LAT_ONE;
    end
  end

  // sequencer: idle takes an instruction, exec counts out the extra cycles
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    done_nxt  = 1'b0;
    case (state_r)
      CCSBD_IDLE: begin
        if (take) begin
          if (lat_sel == LAT_ONE) begin
            done_nxt = 1'b1;
          end else begin
            state_nxt = CCSBD_EXEC;
            cnt_nxt   = lat_sel - 2'h2;
          end
        end
      end
      CCSBD_EXEC: begin
        if (cnt_r == 2'h0) begin
          state_nxt = CCSBD_IDLE;
          done_nxt  = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 2'h1;
        end
      end
      default: begin
        state_nxt = CCSBD_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state_r <= CCSBD_IDLE;
      cnt_r   <= 2'h0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      done_r  <= done_nxt;
    end
  end

  // results captured when the instruction is taken, held until the next
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pc_next_r  <= PC_RST;
      ret_addr_r <= PC_RST;
      status_r   <= STAT_RST;
      st_wr_r    <= 1'b0;
      push_r     <= 1'b0;
      hit_r      <= 1'b0;
    end else if (take) begin
      pc_next_r  <= pc_sel;
      ret_addr_r <= pc_seq;
      status_r   <= is_cimm ? cimm_status : status_in;
      st_wr_r    <= is_cimm;
      push_r     <= is_call;
      hit_r      <= is_any;
    end
  end

  // side effects fire only in the completion cycle; only the compare writes flags
  assign ready_out     = (state_r == CCSBD_IDLE);
  assign done_out      = done_r;
  assign op_hit_out    = hit_r;
  assign pc_load_out   = done_r & hit_r;
  assign pc_next_out   = pc_next_r;
  assign status_out    = status_r;
  assign status_wr_out = done_r & st_wr_r;
  assign ret_push_out  = done_r & push_r;
  assign ret_addr_out  = ret_addr_r;

endmodule : ccsbd_decode

// ==== tb/ccsbd_checker.sv ====
// ccsbd_checker: timing and pc/flag relations of the decode block.
// assumes it is bound to ccsbd_decode and sees only its ports.
`timescale 1ns/1ps
module ccsbd_checker
  import ccsbd_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk_in,
  input wire logic        sys_rst_in,
  // request side
  input wire logic        instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic [15:0] next_word_in,
  input wire logic [15:0] pc_in,
  input wire logic        ready_out,
  input wire logic [7:0]  rd_data_in,
  input wire logic [7:0]  src_data_in,
  input wire logic [7:0]  io_data_in,
  input wire logic [15:0] ptr_in,
  input wire logic [7:0]  status_in,
  // results
  input wire logic [7:0]  status_out,
  input wire logic        status_wr_out,
  input wire logic        done_out,
  input wire logic        pc_load_out,
  input wire logic [15:0] pc_next_out,
  input wire logic        ret_push_out,
  input wire logic [15:0] ret_addr_out
);
  logic take, op_call, op_cimm, op_cskp, op_rclr, op_rset, op_ioclr, op_brf;
  logic cond, skip, noskip, brt, two, cz, cc;
  logic [15:0] tgt;
  logic [7:0]  k8;
  // opcode classes; only call and immediate compare are qualified by take
  assign take     = instr_valid_in && ready_out;
  assign op_call  = take && instr_in == OPC_CALL;
  assign op_cimm  = take && (instr_in & MSK_CIMM) == PAT_CIMM;
  assign op_cskp  = (instr_in & MSK_CSKP) == PAT_CSKP;
  assign op_rclr  = (instr_in & MSK_RBIT) == PAT_RCLR;
  assign op_rset  = (instr_in & MSK_RBIT) == PAT_RSET;
  assign op_ioclr = (instr_in & MSK_IOCLR) == PAT_IOCLR;
  assign op_brf   = (instr_in & MSK_BRF) == PAT_BRF;
  // condition per op; branch falls to the last arm
  assign cond     = op_cskp ? rd_data_in == src_data_in :
                    op_rclr ? !rd_data_in[instr_in[2:0]] :
                    op_rset ? rd_data_in[instr_in[2:0]] :
                    op_ioclr ? !io_data_in[instr_in[2:0]] : status_in[instr_in[2:0]];
  assign skip     = take && (op_cskp || op_rclr || op_rset || op_ioclr) && cond;
  assign noskip   = take && (op_cskp || op_rclr || op_rset || op_ioclr || op_brf) && !cond;
  assign brt      = take && op_brf && cond;
  assign two    = (next_word_in & MSK_LDST2) == PAT_LDST2 ||
                  (next_word_in & MSK_JMPC2) == PAT_JMPC2;
  assign tgt    = pc_in + {{9{instr_in[9]}}, instr_in[9:3]} + PC_STEP;
  assign k8     = {instr_in[11:8], instr_in[3:0]};
  assign cz     = rd_data_in == k8;
  assign cc     = rd_data_in < k8;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  AST_CALL_SEQ: assert property (op_call |=> !ready_out [*2] ##1
    (done_out && ret_push_out && pc_load_out)) else $error("call not done in three cycles");
  AST_CALL_PC: assert property (op_call |=> ##2 (pc_next_out == $past(ptr_in, 3) &&
    ret_addr_out == $past(pc_in, 3) + PC_STEP)) else $error("call target or return wrong");
  AST_CIMM_FLAGS: assert property (op_cimm |=> (done_out && status_wr_out &&
    status_out[SB_Z] == $past(cz) && status_out[SB_C] == $past(cc)))
    else $error("compare immediate flags wrong");
  AST_NO_FLAG_WR: assert property (take && !op_cimm |=> !status_wr_out)
    else $error("status written by flag-neutral op");
  AST_SKIP_ONE: assert property (skip && !two |=> !ready_out ##1
    (done_out && pc_next_out == $past(pc_in, 2) + PC_SKIP1)) else $error("short skip wrong");
  AST_SKIP_TWO: assert property (skip && two |=> !ready_out [*2] ##1
    (done_out && pc_next_out == $past(pc_in, 3) + PC_SKIP2)) else $error("long skip wrong");
  AST_NO_SKIP: assert property (noskip |=> (done_out && ready_out &&
    pc_next_out == $past(pc_in) + PC_STEP)) else $error("untaken op not one cycle");
  AST_BRANCH: assert property (brt |=> !ready_out ##1 (done_out && pc_load_out &&
    pc_next_out == $past(tgt, 2))) else $error("branch target wrong");

  // main scenarios reached
  cover property (op_call);
  cover property (op_cimm);
  cover property (skip && two);
  cover property (brt);
endmodule : ccsbd_checker

bind ccsbd_decode ccsbd_checker u_chk (.sys_clk_in, .sys_rst_in, .instr_valid_in, .instr_in,
  .next_word_in, .pc_in, .ready_out, .rd_data_in, .src_data_in, .io_data_in, .ptr_in,
  .status_in, .status_out, .status_wr_out, .done_out, .pc_load_out, .pc_next_out,
  .ret_push_out, .ret_addr_out);

// ==== tb/call_compare_skip_branch_decode_bench.sv ====
// bench: drives one instruction at a time and judges latency, pc and flags.
// assumes register file, io and status reads are stood in by bench values.
`timescale 1ns/1ps
module call_compare_skip_branch_decode_bench;
  import ccsbd_pkg::*;
  // driven inputs
  logic        clk = 1'b0, rst = 1'b1, vld = 1'b0;
  logic [15:0] ins = 16'h0000, nw = 16'h0000, pc = 16'h0100, ptr = 16'h1234;
  logic [7:0]  rd = 8'h00, src = 8'h00, io = 8'h00, st = 8'h00;
  // observed outputs
  logic        rdy, done, swr, hit, pld, push;
  logic [4:0]  rda, rra, ioa;
  logic [7:0]  so;
  logic [15:0] pcn, ret;
  int          err_count = 0, compares = 0;

  always #4 clk = ~clk;

  ccsbd_decode DUT (.sys_clk_in(clk), .sys_rst_in(rst), .instr_valid_in(vld), .instr_in(ins),
    .next_word_in(nw), .pc_in(pc), .ready_out(rdy), .rd_addr_out(rda), .src_addr_out(rra),
    .rd_data_in(rd), .src_data_in(src), .io_addr_out(ioa), .io_data_in(io), .ptr_in(ptr),
    .status_in(st), .status_out(so), .status_wr_out(swr), .done_out(done), .op_hit_out(hit),
    .pc_load_out(pld), .pc_next_out(pcn), .ret_push_out(push), .ret_addr_out(ret));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one instruction; io shares the rd value, done bounded so a hang shows
  task automatic issue(input logic [15:0] i, w, input logic [7:0] a, b, s,
                       input int lat, input logic [15:0] pe);
    int n;
    @(posedge clk);
    vld <= 1'b1; ins <= i; nw <= w; rd <= a; src <= b; io <= a; st <= s;
    @(posedge clk);
    vld <= 1'b0;
    n = 1;
    @(negedge clk);
    while (done !== 1'b1 && n < 5) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n), 16'(lat));
    chk(pcn, pe);
    chk(16'(pld), 16'h0001);
    chk(16'(hit), 16'h0001);
    chk(16'(swr), 16'((i & MSK_CIMM) == PAT_CIMM));
    if ((i & MSK_CIMM) != PAT_CIMM) chk(16'(so), 16'(s));
  endtask : issue

  task automatic t_ind_call;
    issue(OPC_CALL, 16'h0000, 8'h00, 8'h00, 8'hc0, 3, 16'h1234);
    chk(ret, 16'h0101);
    chk(16'(push), 16'h0001);
    $display("indirect call test done");
  endtask : t_ind_call

  // a word outside the group completes in one cycle and loads nothing
  task automatic t_other;
    @(posedge clk);
    vld <= 1'b1;
    ins <= 16'h0000;
    st  <= 8'h3c;
    @(posedge clk);
    vld <= 1'b0;
    @(negedge clk);
    chk(16'(done), 16'h0001);
    chk(16'(hit), 16'h0000);
    chk(16'(pld), 16'h0000);
    chk(16'(swr), 16'h0000);
    chk(16'(so), 16'h003c);
    $display("non-group word test done");
  endtask : t_other

  // equal, borrow with negative, overflow with half borrow
  task automatic t_cmp_imm;
    issue(16'h3210, 16'h0000, 8'h20, 8'h00, 8'hc0, 1, 16'h0101);
    chk(16'(so), 16'h00c2);
    chk(16'(rda), 16'h0011);
    issue(16'h3210, 16'h0000, 8'h10, 8'h00, 8'hc0, 1, 16'h0101);
    chk(16'(so), 16'h00c5);
    issue(16'h3011, 16'h0000, 8'h80, 8'h00, 8'hc0, 1, 16'h0101);
    chk(16'(so), 16'h00e8);
    $display("compare immediate test done");
  endtask : t_cmp_imm

  task automatic t_cmp_skip;
    issue(16'h1012, 16'h0000, 8'h5a, 8'h5a, 8'hc0, 2, 16'h0102);
    chk(16'(rda), 16'h0001);
    chk(16'(rra), 16'h0002);
    issue(16'h1012, 16'h940c, 8'h5a, 8'h5a, 8'hc0, 3, 16'h0103);
    issue(16'h1012, 16'h940c, 8'h5a, 8'h5b, 8'hc0, 1, 16'h0101);
    $display("compare skip test done");
  endtask : t_cmp_skip

  task automatic t_sbr;
    issue(16'hfc33, 16'h9000, 8'hf7, 8'h00, 8'hc0, 3, 16'h0103);
    chk(16'(rda), 16'h0003);
    issue(16'hfc33, 16'h0000, 8'h08, 8'h00, 8'hc0, 1, 16'h0101);
    issue(16'hfe37, 16'h0000, 8'h80, 8'h00, 8'hc0, 2, 16'h0102);
    issue(16'hfe37, 16'h9000, 8'h7f, 8'h00, 8'hc0, 1, 16'h0101);
    $display("register bit skip test done");
  endtask : t_sbr

  task automatic t_io_bit;
    issue(16'h9928, 16'h0000, 8'hfe, 8'h00, 8'hc0, 2, 16'h0102);
    chk(16'(ioa), 16'h0005);
    issue(16'h9928, 16'h940c, 8'hfe, 8'h00, 8'hc0, 3, 16'h0103);
    issue(16'h9928, 16'h940c, 8'h01, 8'h00, 8'hc0, 1, 16'h0101);
    $display("io bit skip test done");
  endtask : t_io_bit

  // every status bit, negative and largest positive offsets, flag clear
  task automatic t_br_flag;
    for (int s = 0; s < 8; s++) begin
      issue(16'hf000 | 16'(s), 16'h0000, 8'h00, 8'h00, 8'(1 << s), 2, 16'h0101);
    end
    issue(16'hf3f1, 16'h0000, 8'h00, 8'h00, 8'h02, 2, 16'h00ff);
    issue(16'hf1f9, 16'h0000, 8'h00, 8'h00, 8'h02, 2, 16'h0140);
    issue(16'hf3f1, 16'h0000, 8'h00, 8'h00, 8'hfd, 1, 16'h0101);
    $display("flag branch test done");
  endtask : t_br_flag

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // main sequence after a two-cycle reset
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(16'(rdy), 16'h0001);
    t_ind_call;
    t_other;
    t_cmp_imm;
    t_cmp_skip;
    t_sbr;
    t_io_bit;
    t_br_flag;
    report_and_stop;
  end

  // watchdog, well past the fewer than a hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    $display("ERROR %0t: watchdog expired", $time);
    report_and_stop;
  end
endmodule : call_compare_skip_branch_decode_bench
